// ### hdl/timer_pkg.sv
package timer_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam logic [5:0] CTRL_OFS = 6'h00;
    localparam logic [5:0] PRESC_OFS = 6'h04;
    localparam logic [5:0] TIMER_OFS = 6'h08;
    localparam logic [5:0] STATUS_OFS = 6'h0C;
    localparam logic [5:0] MASK_OFS = 6'h10;
    localparam logic [5:0] GPIO_OFS = 6'h14;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int RUN_BIT = 0;
    localparam int POL_BIT = 1;
    localparam int SRC_LSB = 2;
    localparam int PINSEL_BIT = 4;
    localparam int CTRL_W = 5;
    localparam int UF_BIT = 0;
    localparam int EXT_BIT = 1;
    localparam int EVT_W = 2;
    localparam int GPIO_OUT_BIT = 0;
    localparam int GPIO_OE_BIT = 1;
    localparam int PINA_BIT = 2;
    localparam int PINB_BIT = 3;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [7:0] CNT_RST = 8'hFF;
    localparam logic [1:0] EVT_RST = 2'h0;
    localparam logic [1:0] GPIO_RST = 2'h0;
    // ------------------------------------------------------------
    // Count source selection and timing
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_F1 = 2'h0;
    localparam logic [1:0] SRC_F2 = 2'h1;
    localparam logic [1:0] SRC_F8 = 2'h2;
    localparam logic [1:0] SRC_OSC = 2'h3;
    localparam logic [2:0] F8_LAST = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        XF_IDLE = 3'h1,
        XF_RELOAD = 3'h2,
        XF_LOAD = 3'h4
    } xfer_t;
endpackage

// ### hdl/count_source_gen.sv
`timescale 1ns/1ns
module count_source_gen import timer_pkg::*; (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic run,
    input wire logic [1:0] src_sel,
    input wire logic low_speed_osc_clock,
    output logic pulse
);
    logic [2:0] div_reg;
    logic [2:0] sync_reg;
    logic osc_lvl_reg;
    logic pulse_reg;
    // Oscillator edge counts only once stages two and three agree
    wire osc_agree = sync_reg[1] == sync_reg[2];
    wire osc_rise = osc_agree & sync_reg[1] & ~osc_lvl_reg;
    wire tick_f2 = div_reg[0];
    wire tick_f8 = div_reg == F8_LAST;
    wire tick = (src_sel == SRC_F1) ? 1'b1 :
                (src_sel == SRC_F2) ? tick_f2 :
                (src_sel == SRC_F8) ? tick_f8 : osc_rise;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            div_reg <= 3'h0;
            sync_reg <= 3'h0;
            osc_lvl_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 3'h1;
            sync_reg <= {sync_reg[1:0], low_speed_osc_clock};
            if (osc_agree) begin
                osc_lvl_reg <= sync_reg[1];
            end
            pulse_reg <= run & tick;
        end
    end
    // Gate by the live run bit: a tick latched before a stop must not count
    assign pulse = pulse_reg & run;
endmodule

// ### hdl/pin_edge_detect.sv
`timescale 1ns/1ns
module pin_edge_detect (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic rising,
    input wire logic pin,
    output logic level,
    output logic edge_seen
);
    logic [2:0] sync_reg;
    logic lvl_reg;
    logic edge_reg;
    wire agree = sync_reg[1] == sync_reg[2];
    wire change = agree & (sync_reg[1] != lvl_reg);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync_reg <= 3'h7;
            lvl_reg <= 1'b1;
            edge_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], pin};
            if (agree) begin
                lvl_reg <= sync_reg[1];
            end
            edge_reg <= change & (sync_reg[1] == rising);
        end
    end
    assign level = lvl_reg;
    assign edge_seen = edge_reg;
endmodule

// ### hdl/timer_x_timer_mode.sv
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
// Functional notes
// - Only an internal count source counts: f1, f2, f8 or the slow osc.
// - Prescaler and timer count down and reload on underflow, never stop.
// - Overall division is 1/((n+1)(m+1)) for prescaler n and timer m.
// - Writing one to the run bit starts counting.
// - Writing zero to the run bit stops counting; counters hold.
// - Every timer underflow sets its status bit; irq rises only when its mask bit is set.
// - Shared input pins serve as I/O or ext interrupt; counter pin is I/O.
// - Reading timer or prescaler returns the live count, not the reload.
// - A write while stopped loads both reload register and counter.
// - While running, a write reaches reload on pulse 1, counter on 2.
// - A polarity bit picks the edge of the ext interrupt input.
// - Prescaler and timer are 8 bits, each with its own reload register.
// - Reload register and counter share one address; a read gives count.
module timer_x_timer_mode import timer_pkg::*; (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic low_speed_osc_clock,
    input wire logic shared_input_pin_a,
    input wire logic shared_input_pin_b,
    output logic counter_pin_primary_out,
    output logic counter_pin_primary_oe,
    output logic irq
);
    // ------------------------------------------------------------
    // Bus slave state
    // ------------------------------------------------------------
    logic aw_full_reg, w_full_reg, w_lane_reg;
    logic [5:0] aw_addr_reg;
    logic [7:0] w_data_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    // ------------------------------------------------------------
    // Timer state
    // ------------------------------------------------------------
    logic [4:0] ctrl_reg;
    logic [7:0] presc_cnt_reg, presc_rld_reg, presc_wr_reg, presc_next;
    logic [7:0] timer_cnt_reg, timer_rld_reg, timer_wr_reg, timer_next;
    logic pend_presc_reg, pend_timer_reg, irq_reg, cs_pulse;
    xfer_t xf_reg, xf_next;
    logic [1:0] status_reg, mask_reg, gpio_reg;
    logic pin_a_lvl, pin_b_lvl, pin_a_edge, pin_b_edge;
    // ------------------------------------------------------------
    // Write and read channel decode
    // ------------------------------------------------------------
    wire aw_take = awvalid & awready_reg;
    wire w_take = wvalid & wready_reg;
    wire ar_take = arvalid & arready_reg;
    wire wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire wr_en = wr_fire & w_lane_reg;
    wire wr_ctrl = wr_en & (aw_addr_reg == CTRL_OFS);
    wire wr_presc = wr_en & (aw_addr_reg == PRESC_OFS);
    wire wr_timer = wr_en & (aw_addr_reg == TIMER_OFS);
    wire wr_status = wr_en & (aw_addr_reg == STATUS_OFS);
    wire wr_mask = wr_en & (aw_addr_reg == MASK_OFS);
    wire wr_gpio = wr_en & (aw_addr_reg == GPIO_OFS);
    wire wr_hit = (aw_addr_reg == CTRL_OFS) | (aw_addr_reg == PRESC_OFS)
        | (aw_addr_reg == TIMER_OFS) | (aw_addr_reg == STATUS_OFS)
        | (aw_addr_reg == MASK_OFS) | (aw_addr_reg == GPIO_OFS);
    wire aw_full_next = ~wr_fire & (aw_full_reg | aw_take);
    wire w_full_next = ~wr_fire & (w_full_reg | w_take);
    wire bvalid_next = wr_fire | (bvalid_reg & ~bready);
    wire rvalid_next = ar_take | (rvalid_reg & ~rready);
    wire [5:0] ar_ofs = araddr[5:0];
    wire ar_hi_zero = araddr[31:6] == 26'h0;
    wire [31:0] rd_value;
    wire rd_hit;
    // Live counts are read, never the reload values
    assign rd_value =
        (ar_ofs == CTRL_OFS) ? {27'h0, ctrl_reg} :
        (ar_ofs == PRESC_OFS) ? {24'h0, presc_cnt_reg} :
        (ar_ofs == TIMER_OFS) ? {24'h0, timer_cnt_reg} :
        (ar_ofs == STATUS_OFS) ? {30'h0, status_reg} :
        (ar_ofs == MASK_OFS) ? {30'h0, mask_reg} :
        (ar_ofs == GPIO_OFS) ? {28'h0, pin_b_lvl, pin_a_lvl, gpio_reg} :
        32'h0;
    assign rd_hit = ar_hi_zero & ((ar_ofs == CTRL_OFS)
        | (ar_ofs == PRESC_OFS) | (ar_ofs == TIMER_OFS)
        | (ar_ofs == STATUS_OFS) | (ar_ofs == MASK_OFS)
        | (ar_ofs == GPIO_OFS));
    // ------------------------------------------------------------
    // Count source and pins
    // ------------------------------------------------------------
    wire run = ctrl_reg[RUN_BIT];
    count_source_gen u_src (
        .core_clk(core_clk),
        .srst(srst),
        .run(run),
        .src_sel(ctrl_reg[SRC_LSB +: 2]),
        .low_speed_osc_clock(low_speed_osc_clock),
        .pulse(cs_pulse)
    );
    pin_edge_detect u_pin_a (
        .core_clk(core_clk),
        .srst(srst),
        .rising(ctrl_reg[POL_BIT]),
        .pin(shared_input_pin_a),
        .level(pin_a_lvl),
        .edge_seen(pin_a_edge)
    );
    pin_edge_detect u_pin_b (
        .core_clk(core_clk),
        .srst(srst),
        .rising(ctrl_reg[POL_BIT]),
        .pin(shared_input_pin_b),
        .level(pin_b_lvl),
        .edge_seen(pin_b_edge)
    );
    // Either shared pin may feed the ext interrupt, never the counter
    wire ext_evt = ctrl_reg[PINSEL_BIT] ? pin_b_edge : pin_a_edge;
    // ------------------------------------------------------------
    // Counting and write transfer
    // ------------------------------------------------------------
    // Counting pauses for the two pulses of a running-write transfer
    wire counting = cs_pulse & (xf_reg == XF_IDLE);
    wire presc_uf = counting & (presc_cnt_reg == 8'h00);
    wire timer_uf = presc_uf & (timer_cnt_reg == 8'h00);
    wire wr_run = (wr_presc | wr_timer) & run;
    always_comb begin
        xf_next = xf_reg;
        if (wr_run) begin
            xf_next = XF_RELOAD;
        end else if (cs_pulse) begin
            case (xf_reg)
                XF_RELOAD: xf_next = XF_LOAD;
                XF_LOAD: xf_next = XF_IDLE;
                default: xf_next = XF_IDLE;
            endcase
        end
    end
    always_comb begin
        presc_next = presc_cnt_reg;
        timer_next = timer_cnt_reg;
        if (presc_uf) begin
            presc_next = presc_rld_reg;
        end else if (counting) begin
            presc_next = presc_cnt_reg - 8'h01;
        end
        if (timer_uf) begin
            timer_next = timer_rld_reg;
        end else if (presc_uf) begin
            timer_next = timer_cnt_reg - 8'h01;
        end
        if (cs_pulse & (xf_reg == XF_LOAD) & ~wr_run) begin
            if (pend_presc_reg) begin
                presc_next = presc_rld_reg;
            end
            if (pend_timer_reg) begin
                timer_next = timer_rld_reg;
            end
        end
        if (wr_presc & ~run) begin
            presc_next = w_data_reg;
        end
        if (wr_timer & ~run) begin
            timer_next = w_data_reg;
        end
    end
    wire xf_stage1 = cs_pulse & (xf_reg == XF_RELOAD) & ~wr_run;
    wire xf_done = cs_pulse & (xf_reg == XF_LOAD) & ~wr_run;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            presc_cnt_reg <= CNT_RST;
            timer_cnt_reg <= CNT_RST;
            xf_reg <= XF_IDLE;
        end else begin
            presc_cnt_reg <= presc_next;
            timer_cnt_reg <= timer_next;
            xf_reg <= xf_next;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            presc_rld_reg <= CNT_RST;
            presc_wr_reg <= CNT_RST;
            pend_presc_reg <= 1'b0;
        end else if (wr_presc) begin
            presc_wr_reg <= w_data_reg;
            pend_presc_reg <= run;
            if (~run) begin
                presc_rld_reg <= w_data_reg;
            end
        end else if (xf_stage1 & pend_presc_reg) begin
            presc_rld_reg <= presc_wr_reg;
        end else if (xf_done) begin
            pend_presc_reg <= 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            timer_rld_reg <= CNT_RST;
            timer_wr_reg <= CNT_RST;
            pend_timer_reg <= 1'b0;
        end else if (wr_timer) begin
            timer_wr_reg <= w_data_reg;
            pend_timer_reg <= run;
            if (~run) begin
                timer_rld_reg <= w_data_reg;
            end
        end else if (xf_stage1 & pend_timer_reg) begin
            timer_rld_reg <= timer_wr_reg;
        end else if (xf_done) begin
            pend_timer_reg <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Control, status, mask, pin and interrupt registers
    // ------------------------------------------------------------
    wire [1:0] evt_set = {ext_evt, timer_uf};
    // A new event beats a write-one clear in the same cycle
    wire [1:0] evt_clr = wr_status ? w_data_reg[1:0] : 2'h0;
    wire [1:0] status_next = evt_set | (status_reg & ~evt_clr);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_reg <= CTRL_RST;
            status_reg <= EVT_RST;
            mask_reg <= EVT_RST;
            gpio_reg <= GPIO_RST;
            irq_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= w_data_reg[CTRL_W-1:0];
            end
            if (wr_mask) begin
                mask_reg <= w_data_reg[1:0];
            end
            if (wr_gpio) begin
                gpio_reg <= w_data_reg[1:0];
            end
            status_reg <= status_next;
            irq_reg <= |(status_next & mask_reg);
        end
    end
    // ------------------------------------------------------------
    // Bus handshake registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 6'h00;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awready_reg <= ~aw_full_next & ~bvalid_next;
            wready_reg <= ~w_full_next & ~bvalid_next;
            bvalid_reg <= bvalid_next;
            if (aw_take) begin
                // Upper address bits set force a miss
                aw_addr_reg <= (awaddr[31:6] == 26'h0) ? awaddr[5:0] : 6'h3F;
            end
            if (w_take) begin
                w_data_reg <= wdata[7:0];
                w_lane_reg <= wstrb[0];
            end
            if (wr_fire) begin
                bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end else begin
            arready_reg <= ~rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_take) begin
                rdata_reg <= rd_value;
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign counter_pin_primary_out = gpio_reg[GPIO_OUT_BIT];
    assign counter_pin_primary_oe = gpio_reg[GPIO_OE_BIT];
    assign irq = irq_reg;
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    presc_step_a: assert property (
        counting & ~wr_en & (presc_cnt_reg != 8'h00)
        |=> presc_cnt_reg == $past(presc_cnt_reg) - 8'h01)
        else $error("prescaler did not step down");
    presc_reload_a: assert property (
        presc_uf & ~wr_en |=> presc_cnt_reg == $past(presc_rld_reg))
        else $error("prescaler did not reload");
    timer_step_a: assert property (
        presc_uf & ~wr_en & (timer_cnt_reg != 8'h00)
        |=> timer_cnt_reg == $past(timer_cnt_reg) - 8'h01)
        else $error("timer did not step on prescaler underflow");
    underflow_flag_a: assert property (
        timer_uf |=> status_reg[UF_BIT] && (irq || !$past(mask_reg[UF_BIT])))
        else $error("underflow not flagged");
    stop_hold_a: assert property (
        ~run & ~wr_en |=> $stable(presc_cnt_reg) && $stable(timer_cnt_reg))
        else $error("counters moved while stopped");
    run_start_a: assert property (
        wr_ctrl & w_data_reg[RUN_BIT] |=> run ##1 1'b1)
        else $error("run bit not set");
    stop_write_a: assert property (
        wr_timer & ~run |=> timer_cnt_reg == $past(w_data_reg)
        && timer_rld_reg == $past(w_data_reg))
        else $error("stopped write missed counter or reload");
    xfer_seq_a: assert property (
        xf_stage1 |=> xf_reg == XF_LOAD && !counting)
        else $error("transfer did not advance");
    read_live_a: assert property (
        ar_take & (araddr == {26'h0, TIMER_OFS})
        |=> rdata == {24'h0, $past(timer_cnt_reg)})
        else $error("read did not return live count");
    ext_edge_a: assert property (
        ext_evt |=> status_reg[EXT_BIT])
        else $error("ext interrupt edge lost");
    resp_pair_a: assert property (
        wr_fire |=> bvalid)
        else $error("no write response");
    underflow_c: cover property (timer_uf ##[1:40] timer_uf);
    xfer_c: cover property (xf_stage1 ##[1:20] xf_done);
    ext_c: cover property (ext_evt ##1 irq);
endmodule

// ### tb/timer_x_timer_mode_test.sv
`timescale 1ns/1ns
module timer_x_timer_mode_test;
import timer_pkg::*;
logic core_clk, srst, awvalid, wvalid, bready, arvalid, rready;
logic awready, wready, bvalid, arready, rvalid, irq, osc, pin_a, pin_b;
logic pin_out, pin_oe;
logic [31:0] awaddr, wdata, araddr, rdata, v;
logic [1:0] bresp, rresp;
int fail_count, total_checks, cyc, t0, t1;
int dv[4] = '{1, 2, 8, 10};
timer_x_timer_mode u_timer_x_timer_mode (.core_clk(core_clk),
    .srst(srst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .low_speed_osc_clock(osc), .shared_input_pin_a(pin_a),
    .shared_input_pin_b(pin_b), .counter_pin_primary_out(pin_out),
    .counter_pin_primary_oe(pin_oe), .irq(irq));
// ------------------------------------------------------------
// Clock, slow oscillator and hang guard
// ------------------------------------------------------------
initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
end
// Slow source ticks every 10 core cycles so its periods are exact
always begin
    repeat (5) @(posedge core_clk);
    osc <= ~osc;
end
always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
        fail_count++;
        complete_run();
    end
end
// ------------------------------------------------------------
// Bus tasks
// ------------------------------------------------------------
task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
        fail_count++;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
endtask
task automatic wr(input logic [5:0] a, input logic [31:0] d,
                  input logic [1:0] er);
    awaddr <= {26'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
        @(posedge core_clk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    @(posedge core_clk);
endtask
task automatic rd(input logic [5:0] a, input logic [1:0] er);
    araddr <= {26'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
        @(posedge core_clk);
        if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    @(posedge core_clk);
endtask
task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    rd(a, RESP_OKAY);
    chk("rdata", v, e);
endtask
task automatic wirq(output int t);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
        @(posedge core_clk);
        n++;
    end
    chk("irq wait", 32'(n < 3000), 32'h1);
    t = cyc;
endtask
task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
// ------------------------------------------------------------
// Tests
// ------------------------------------------------------------
initial begin
    {awvalid, wvalid, bready, arvalid, rready, osc} = 6'h00;
    {awaddr, wdata, araddr, cyc, fail_count, total_checks} = '0;
    srst = 1'b1;
    pin_a = 1'b1;
    pin_b = 1'b1;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    rdc(CTRL_OFS, 32'h0);
    rdc(PRESC_OFS, 32'hFF);
    rdc(TIMER_OFS, 32'hFF);
    rdc(STATUS_OFS, 32'h0);
    rdc(GPIO_OFS, 32'hC);
    rd(6'h18, RESP_SLVERR);
    chk("unmapped", v, 32'h0);
    wr(6'h18, 32'h1, RESP_SLVERR);
    wr(PRESC_OFS, 32'h3, RESP_OKAY);
    wr(TIMER_OFS, 32'h2, RESP_OKAY);
    rdc(PRESC_OFS, 32'h3);
    rdc(TIMER_OFS, 32'h2);
    $display("reset and stopped load done");
    wr(MASK_OFS, 32'h1, RESP_OKAY);
    for (int s = 0; s < 4; s++) begin
        wr(CTRL_OFS, {28'h0, 2'(s), 2'b01}, RESP_OKAY);
        wirq(t0);
        wr(STATUS_OFS, 32'h1, RESP_OKAY);
        wirq(t1);
        chk("period", 32'(t1 - t0), 32'(12 * dv[s]));
        wr(CTRL_OFS, 32'h0, RESP_OKAY);
        wr(STATUS_OFS, 32'h1, RESP_OKAY);
        chk("irq clear", {31'h0, irq}, 32'h0);
    end
    rd(TIMER_OFS, RESP_OKAY);
    t0 = v;
    repeat (30) @(posedge core_clk);
    rdc(TIMER_OFS, 32'(t0));
    $display("sources and period done");
    wr(PRESC_OFS, 32'h0, RESP_OKAY);
    wr(TIMER_OFS, 32'h20, RESP_OKAY);
    wr(CTRL_OFS, 32'h9, RESP_OKAY);
    repeat (80) @(posedge core_clk);
    rd(TIMER_OFS, RESP_OKAY);
    chk("live", 32'(v < 32'h20 && v > 32'h10), 32'h1);
    wr(TIMER_OFS, 32'h5, RESP_OKAY);
    rd(TIMER_OFS, RESP_OKAY);
    chk("not yet", 32'(v > 32'h5), 32'h1);
    repeat (40) @(posedge core_clk);
    rd(TIMER_OFS, RESP_OKAY);
    chk("loaded", 32'(v <= 32'h5), 32'h1);
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    wr(STATUS_OFS, 32'h1, RESP_OKAY);
    $display("running write done");
    wr(MASK_OFS, 32'h0, RESP_OKAY);
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    repeat (20) @(posedge core_clk);
    chk("masked irq", {31'h0, irq}, 32'h0);
    rdc(STATUS_OFS, 32'h1);
    wr(MASK_OFS, 32'h1, RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk("unmasked irq", {31'h0, irq}, 32'h1);
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    wr(STATUS_OFS, 32'h1, RESP_OKAY);
    $display("mask done");
    wr(MASK_OFS, 32'h2, RESP_OKAY);
    pin_a <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk("fall a", {31'h0, irq}, 32'h1);
    rdc(STATUS_OFS, 32'h2);
    wr(STATUS_OFS, 32'h2, RESP_OKAY);
    pin_a <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("rise a", {31'h0, irq}, 32'h0);
    wr(CTRL_OFS, 32'h12, RESP_OKAY);
    pin_b <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk("fall b", {31'h0, irq}, 32'h0);
    pin_b <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("rise b", {31'h0, irq}, 32'h1);
    wr(STATUS_OFS, 32'h2, RESP_OKAY);
    wr(GPIO_OFS, 32'h3, RESP_OKAY);
    chk("pin", {30'h0, pin_oe, pin_out}, 32'h3);
    rdc(GPIO_OFS, 32'hF);
    $display("pins done");
    complete_run();
end
endmodule
